//--- gse_engine.sv
// shape drawing engine: apb registers, scan and line walkers, pixel port
// Notes on behaviour
// - ellipse field 00b draws a circle or ellipse around the centre with both radii
// - ellipse field 01b draws one quarter arc or quarter ellipse around the centre
// - ellipse field 10b draws a rectangle between start and end corners
// - ellipse field 11b draws a rounded rectangle, corners shaped by the radii
// - writing one to bit 7 of the ellipse control starts those shapes
// - ellipse fill bit set fills the shape interior with the colour
// - line select bit zero draws a straight line start to end
// - line select bit one draws a triangle from start, end and third point
// - writing one to bit 7 of the line control starts line or triangle
// - triangle fill bit set fills the triangle interior
// - every shape uses the three colour bytes loaded before the start
// - rounded corners use radius one horizontally and radius two vertically
//
// Local design decision: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module gse_engine #(
    parameter int ADDR_W = 10
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic pix_valid,
    input wire logic pix_ready,
    output gse_pkg::gse_pix_t pix
);
    logic [7:0] idx;
    logic is_par, is_ctl, wr_en, rf_we;
    logic [4:0] lidx;
    logic [7:0] rf_rdata;
    logic [8*gse_pkg::NBYTES-1:0] flat;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr;
    gse_pkg::gse_geo_t geo_in, geo, next_geo;
    logic [23:0] col_in, color, next_color;
    gse_pkg::gse_state_t state, next_state;
    gse_pkg::gse_shape_t ls, shape, next_shape, nb_shape;
    logic [7:0] line_ctl, next_line_ctl, ell_ctl, next_ell_ctl;
    logic fill, next_fill;
    logic [1:0] quad, next_quad;
    logic signed [17:0] cur_x, cur_y, next_x, next_y;
    logic signed [17:0] lo_x, hi_x, hi_y, next_lo_x, next_hi_x, next_hi_y;
    logic signed [17:0] b_lo_x, b_hi_x, b_lo_y, b_hi_y;
    logic signed [17:0] gsx, gsy, gex, gey, gtx, gty, gcx, gcy, gr1, gr2;
    logic signed [18:0] ldx, ldy, err, next_ldx, next_ldy, next_err;
    logic signed [19:0] e2;
    logic stx, sty, next_stx, next_sty;
    logic next_pix_valid;
    gse_pkg::gse_pix_t next_pix;
    logic can_go, hit, outline;
    logic signed [17:0] nbx [5];
    logic signed [17:0] nby [5];
    logic [4:0] nb_in;

    // apb address decode; pstrb lane 0 carries the only byte
    always_comb begin
        idx = paddr[9:2];
        is_ctl = (idx == gse_pkg::IDX_LINE_CTL) || (idx == gse_pkg::IDX_ELL_CTL);
        if (idx >= gse_pkg::IDX_PAR_LO && idx <= gse_pkg::IDX_PAR_HI) begin
            is_par = 1'b1;
            lidx = 5'(idx - gse_pkg::IDX_PAR_LO);
        end else if (idx >= gse_pkg::IDX_RAD_LO && idx <= gse_pkg::IDX_CTR_HI) begin
            is_par = 1'b1;
            lidx = 5'(idx - gse_pkg::IDX_PAR_LO);
        end else if (idx >= gse_pkg::IDX_COL_LO && idx <= gse_pkg::IDX_COL_HI) begin
            is_par = 1'b1;
            lidx = 5'(idx - gse_pkg::IDX_COL_LO) + gse_pkg::B_COL;
        end else begin
            is_par = 1'b0;
            lidx = 5'h00;
        end
        // writes land only on the completing edge of the access phase
        wr_en = psel && penable && pready && pwrite && pstrb[0];
        rf_we = wr_en && is_par;
    end

    gse_regfile #(
        .NBYTES(gse_pkg::NBYTES)
    ) u_regs (
        .pclk(pclk),
        .presetn(presetn),
        .we(rf_we),
        .waddr(lidx),
        .wdata(pwdata[7:0]),
        .raddr(lidx),
        .rdata(rf_rdata),
        .flat(flat)
    );

    // one wait state gives the registered store time to answer
    always_comb begin
        next_pready = psel && penable && !pready;
        next_prdata = prdata;
        next_pslverr = 1'b0;
        if (psel && penable && !pready) begin
            next_pslverr = !(is_par || is_ctl);
            if (idx == gse_pkg::IDX_LINE_CTL) begin
                next_prdata = {24'h000000, line_ctl};
            end else if (idx == gse_pkg::IDX_ELL_CTL) begin
                next_prdata = {24'h000000, ell_ctl};
            end else if (is_par && !pwrite) begin
                next_prdata = {24'h000000, rf_rdata};
            end else begin
                next_prdata = 32'h00000000;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready <= next_pready;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // geometry and colour as loaded; latched at launch
    always_comb begin
        geo_in.sx = flat[8*gse_pkg::B_SX +: 16];
        geo_in.sy = flat[8*gse_pkg::B_SY +: 16];
        geo_in.ex = flat[8*gse_pkg::B_EX +: 16];
        geo_in.ey = flat[8*gse_pkg::B_EY +: 16];
        geo_in.tx = flat[8*gse_pkg::B_TX +: 16];
        geo_in.ty = flat[8*gse_pkg::B_TY +: 16];
        geo_in.r1 = flat[8*gse_pkg::B_R1 +: 16];
        geo_in.r2 = flat[8*gse_pkg::B_R2 +: 16];
        geo_in.cx = flat[8*gse_pkg::B_CX +: 16];
        geo_in.cy = flat[8*gse_pkg::B_CY +: 16];
        col_in = {flat[8*23 +: 8], flat[8*24 +: 8], flat[8*25 +: 8]};
        gsx = signed'({2'b00, geo_in.sx});
        gsy = signed'({2'b00, geo_in.sy});
        gex = signed'({2'b00, geo_in.ex});
        gey = signed'({2'b00, geo_in.ey});
        gtx = signed'({2'b00, geo_in.tx});
        gty = signed'({2'b00, geo_in.ty});
        gcx = signed'({2'b00, geo_in.cx});
        gcy = signed'({2'b00, geo_in.cy});
        gr1 = signed'({2'b00, geo_in.r1});
        gr2 = signed'({2'b00, geo_in.r2});
    end

    // shape being launched and the box the scan must cover
    always_comb begin
        ls = gse_pkg::SH_TRI;
        if (idx == gse_pkg::IDX_ELL_CTL) begin
            case (pwdata[gse_pkg::ELL_SHAPE_LSB +: 2])
                gse_pkg::SHP_ELL: ls = gse_pkg::SH_ELL;
                gse_pkg::SHP_QUAD: ls = gse_pkg::SH_QUAD;
                gse_pkg::SHP_RECT: ls = gse_pkg::SH_RECT;
                default: ls = gse_pkg::SH_RRECT;
            endcase
        end
        b_lo_x = (gsx < gex) ? gsx : gex;
        b_hi_x = (gsx < gex) ? gex : gsx;
        b_lo_y = (gsy < gey) ? gsy : gey;
        b_hi_y = (gsy < gey) ? gey : gsy;
        if (ls == gse_pkg::SH_ELL || ls == gse_pkg::SH_QUAD) begin
            b_lo_x = gcx - gr1;
            b_hi_x = gcx + gr1;
            b_lo_y = gcy - gr2;
            b_hi_y = gcy + gr2;
        end else if (ls == gse_pkg::SH_TRI) begin
            b_lo_x = (gtx < b_lo_x) ? gtx : b_lo_x;
            b_hi_x = (gtx > b_hi_x) ? gtx : b_hi_x;
            b_lo_y = (gty < b_lo_y) ? gty : b_lo_y;
            b_hi_y = (gty > b_hi_y) ? gty : b_hi_y;
        end
    end

    // neighbours decide the outline; the quarter arc ignores its cut edges
    always_comb begin
        nb_shape = (shape == gse_pkg::SH_QUAD) ? gse_pkg::SH_ELL : shape;
        nbx[0] = cur_x;
        nby[0] = cur_y;
        nbx[1] = cur_x - 18'sd1;
        nby[1] = cur_y;
        nbx[2] = cur_x + 18'sd1;
        nby[2] = cur_y;
        nbx[3] = cur_x;
        nby[3] = cur_y - 18'sd1;
        nbx[4] = cur_x;
        nby[4] = cur_y + 18'sd1;
    end

    for (genvar k = 0; k < 5; k++) begin : g_nb
        gse_inside u_in (
            .px(nbx[k]),
            .py(nby[k]),
            .shape((k == 0) ? shape : nb_shape),
            .quad(quad),
            .geo(geo),
            .in_shape(nb_in[k])
        );
    end

    // drawing sequencer; stalls whenever the pixel port holds a pixel while pix_ready is low
    always_comb begin
        next_state = state;
        next_line_ctl = line_ctl;
        next_ell_ctl = ell_ctl;
        next_geo = geo;
        next_color = color;
        next_shape = shape;
        next_fill = fill;
        next_quad = quad;
        next_x = cur_x;
        next_y = cur_y;
        next_lo_x = lo_x;
        next_hi_x = hi_x;
        next_hi_y = hi_y;
        next_ldx = ldx;
        next_ldy = ldy;
        next_err = err;
        next_stx = stx;
        next_sty = sty;
        next_pix = pix;
        next_pix_valid = pix_valid && !pix_ready;
        can_go = !pix_valid || pix_ready;
        outline = !(nb_in[1] && nb_in[2] && nb_in[3] && nb_in[4]);
        hit = nb_in[0] && (fill || outline) && cur_x >= 0 && cur_y >= 0;
        e2 = 20'(err) <<< 1;
        case (state)
            gse_pkg::ST_IDLE: begin
                // control writes are ignored, without pslverr, while a shape is drawing
                if (wr_en && idx == gse_pkg::IDX_LINE_CTL) begin
                    next_line_ctl = pwdata[7:0];
                    if (pwdata[gse_pkg::BIT_START]) begin
                        next_geo = geo_in;
                        next_color = col_in;
                        next_shape = gse_pkg::SH_TRI;
                        next_fill = pwdata[gse_pkg::BIT_TRI_FILL];
                        if (pwdata[gse_pkg::BIT_TRI_SEL]) begin
                            next_state = gse_pkg::ST_SCAN;
                            next_x = b_lo_x;
                            next_y = b_lo_y;
                        end else begin
                            next_state = gse_pkg::ST_LINE;
                            next_x = gsx;
                            next_y = gsy;
                        end
                        next_ldx = (gex >= gsx) ? 19'(gex - gsx) : 19'(gsx - gex);
                        next_ldy = (gey >= gsy) ? 19'(gsy - gey) : 19'(gey - gsy);
                        next_err = next_ldx + next_ldy;
                        next_stx = (gex >= gsx);
                        next_sty = (gey >= gsy);
                        next_lo_x = b_lo_x;
                        next_hi_x = b_hi_x;
                        next_hi_y = b_hi_y;
                    end
                end else if (wr_en && idx == gse_pkg::IDX_ELL_CTL) begin
                    next_ell_ctl = pwdata[7:0];
                    if (pwdata[gse_pkg::BIT_START]) begin
                        next_geo = geo_in;
                        next_color = col_in;
                        next_shape = ls;
                        next_fill = pwdata[gse_pkg::BIT_ELL_FILL];
                        next_quad = pwdata[gse_pkg::QUAD_LSB +: 2];
                        next_state = gse_pkg::ST_SCAN;
                        next_x = b_lo_x;
                        next_y = b_lo_y;
                        next_lo_x = b_lo_x;
                        next_hi_x = b_hi_x;
                        next_hi_y = b_hi_y;
                    end
                end
            end
            gse_pkg::ST_SCAN: begin
                if (can_go) begin
                    next_pix_valid = hit;
                    next_pix = '{x: cur_x[15:0], y: cur_y[15:0], color: color};
                    if (cur_x == hi_x) begin
                        next_x = lo_x;
                        next_y = cur_y + 18'sd1;
                        if (cur_y == hi_y) begin
                            next_state = gse_pkg::ST_DRAIN;
                        end
                    end else begin
                        next_x = cur_x + 18'sd1;
                    end
                end
            end
            gse_pkg::ST_LINE: begin
                // integer line walk, one pixel per free slot
                if (can_go) begin
                    next_pix_valid = 1'b1;
                    next_pix = '{x: cur_x[15:0], y: cur_y[15:0], color: color};
                    if (cur_x == signed'({2'b00, geo.ex}) && cur_y == signed'({2'b00, geo.ey})) begin
                        next_state = gse_pkg::ST_DRAIN;
                    end else begin
                        next_err = err + ((e2 >= 20'(ldy)) ? ldy : 19'sd0)
                            + ((e2 <= 20'(ldx)) ? ldx : 19'sd0);
                        if (e2 >= 20'(ldy)) begin
                            next_x = stx ? cur_x + 18'sd1 : cur_x - 18'sd1;
                        end
                        if (e2 <= 20'(ldx)) begin
                            next_y = sty ? cur_y + 18'sd1 : cur_y - 18'sd1;
                        end
                    end
                end
            end
            default: begin
                // start bit drops only after the last pixel was taken
                if (can_go) begin
                    next_line_ctl[gse_pkg::BIT_START] = 1'b0;
                    next_ell_ctl[gse_pkg::BIT_START] = 1'b0;
                    next_state = gse_pkg::ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= gse_pkg::ST_IDLE;
            line_ctl <= gse_pkg::CTL_RST;
            ell_ctl <= gse_pkg::CTL_RST;
            geo <= '0;
            color <= 24'h000000;
            shape <= gse_pkg::SH_ELL;
            fill <= 1'b0;
            quad <= 2'h0;
            cur_x <= '0;
            cur_y <= '0;
            lo_x <= '0;
            hi_x <= '0;
            hi_y <= '0;
            ldx <= '0;
            ldy <= '0;
            err <= '0;
            stx <= 1'b0;
            sty <= 1'b0;
            pix_valid <= 1'b0;
            pix <= '0;
        end else begin
            state <= next_state;
            line_ctl <= next_line_ctl;
            ell_ctl <= next_ell_ctl;
            geo <= next_geo;
            color <= next_color;
            shape <= next_shape;
            fill <= next_fill;
            quad <= next_quad;
            cur_x <= next_x;
            cur_y <= next_y;
            lo_x <= next_lo_x;
            hi_x <= next_hi_x;
            hi_y <= next_hi_y;
            ldx <= next_ldx;
            ldy <= next_ldy;
            err <= next_err;
            stx <= next_stx;
            sty <= next_sty;
            pix_valid <= next_pix_valid;
            pix <= next_pix;
        end
    end
endmodule
`default_nettype wire

//--- gse_engine_asserts.sv
// port checker for the shape drawing engine
`timescale 1ns/10ps
`default_nettype none
module gse_engine_asserts #(
    parameter int ADDR_W = 10
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic pix_valid,
    input wire logic pix_ready,
    input wire gse_pkg::gse_pix_t pix
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // answer only inside an access phase, after exactly one wait state
    a_ready_access: assert property (pready |-> psel && penable && $past(penable))
        else $error("pready outside access phase");
    a_one_wait: assert property (psel && $rose(penable) |=> pready)
        else $error("access phase not answered after one wait");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_rdata_high: assert property (pready |-> prdata[31:8] == 24'h000000)
        else $error("upper read data not zero");
    a_unmapped_err: assert property (pready && paddr[9:2] inside {8'h74, 8'h75}
        |-> pslverr && prdata == 32'h00000000)
        else $error("unmapped index not refused");
    a_mapped_ok: assert property (pready && paddr[9:2] == 8'h76 |-> !pslverr)
        else $error("mapped index refused");
    // a stalled pixel must not move, or memory would lose it
    a_pix_hold: assert property (pix_valid && !pix_ready |=> pix_valid && $stable(pix))
        else $error("pixel changed while stalled");
    a_color_const: assert property (pix_valid && $past(pix_valid)
        |-> pix.color == $past(pix.color))
        else $error("colour changed inside a shape");
endmodule
bind gse_engine gse_engine_asserts #(.ADDR_W(ADDR_W)) gse_engine_asserts_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pix_valid(pix_valid), .pix_ready(pix_ready), .pix(pix));
`default_nettype wire

//--- gse_inside.sv
// point-in-shape test for every area shape the engine scans
`timescale 1ns/10ps
`default_nettype none
module gse_inside (
    input wire logic signed [17:0] px,
    input wire logic signed [17:0] py,
    input wire gse_pkg::gse_shape_t shape,
    input wire logic [1:0] quad,
    input wire gse_pkg::gse_geo_t geo,
    output logic in_shape
);
    logic signed [17:0] sx, sy, ex, ey, tx, ty, r1, r2, lx, hx, ly, hy, ox, oy, dx, dy;
    logic [35:0] dx2, dy2, a2, b2;
    logic [71:0] lhs, rhs;
    logic signed [37:0] e0, e1, e2;
    logic in_rect, in_ell, in_quad, in_tri;

    always_comb begin
        sx = signed'({2'b00, geo.sx});
        sy = signed'({2'b00, geo.sy});
        ex = signed'({2'b00, geo.ex});
        ey = signed'({2'b00, geo.ey});
        tx = signed'({2'b00, geo.tx});
        ty = signed'({2'b00, geo.ty});
        r1 = signed'({2'b00, geo.r1});
        r2 = signed'({2'b00, geo.r2});
        lx = (sx < ex) ? sx : ex;
        hx = (sx < ex) ? ex : sx;
        ly = (sy < ey) ? sy : ey;
        hy = (sy < ey) ? ey : sy;
        // corner arcs: r1 runs horizontally, r2 vertically
        if (shape == gse_pkg::SH_RRECT) begin
            ox = (px < lx + r1) ? lx + r1 : ((px > hx - r1) ? hx - r1 : px);
            oy = (py < ly + r2) ? ly + r2 : ((py > hy - r2) ? hy - r2 : py);
        end else begin
            ox = signed'({2'b00, geo.cx});
            oy = signed'({2'b00, geo.cy});
        end
        dx = px - ox;
        dy = py - oy;
        dx2 = $unsigned(36'(dx * dx));
        dy2 = $unsigned(36'(dy * dy));
        a2 = 36'(geo.r1 * geo.r1);
        b2 = 36'(geo.r2 * geo.r2);
        // scaled ellipse equation avoids any divider
        lhs = dx2 * b2 + dy2 * a2;
        rhs = a2 * b2;
        in_ell = (lhs <= rhs);
        in_quad = (quad[0] ? (dx <= 0) : (dx >= 0)) && (quad[1] ? (dy <= 0) : (dy >= 0));
        in_rect = (px >= lx) && (px <= hx) && (py >= ly) && (py <= hy);
        // edge functions: inside when all share one sign
        e0 = (ex - sx) * (py - sy) - (ey - sy) * (px - sx);
        e1 = (tx - ex) * (py - ey) - (ty - ey) * (px - ex);
        e2 = (sx - tx) * (py - ty) - (sy - ty) * (px - tx);
        in_tri = ((e0 >= 0) && (e1 >= 0) && (e2 >= 0)) || ((e0 <= 0) && (e1 <= 0) && (e2 <= 0));
        case (shape)
            gse_pkg::SH_ELL: in_shape = in_ell;
            gse_pkg::SH_QUAD: in_shape = in_ell && in_quad;
            gse_pkg::SH_RECT: in_shape = in_rect;
            gse_pkg::SH_RRECT: in_shape = in_rect && in_ell;
            default: in_shape = in_tri;
        endcase
    end
endmodule
`default_nettype wire

//--- gse_pixmem.sv
// display memory model: takes pixels, keeps count, bounds and a probe hit
`timescale 1ns/10ps
`default_nettype none
module gse_pixmem (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clr,
    input wire logic slow,
    input wire logic [15:0] px,
    input wire logic [15:0] py,
    input wire logic pix_valid,
    input wire gse_pkg::gse_pix_t pix,
    output logic pix_ready,
    output logic [15:0] cnt,
    output logic hit,
    output logic [15:0] xlo,
    output logic [15:0] xhi,
    output logic [15:0] ylo,
    output logic [15:0] yhi,
    output logic [23:0] col
);
    logic tog;
    // slow mode refuses every other cycle to stall the engine
    assign pix_ready = !slow || tog;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) tog <= 1'h0;
        else tog <= ~tog;
    end
    // statistics of accepted pixels only
    always @(posedge pclk) begin
        if (clr) begin
            {cnt, hit, xhi, yhi, col} <= '0;
            {xlo, ylo} <= 32'hFFFFFFFF;
        end else if (pix_valid && pix_ready) begin
            cnt <= cnt + 16'h1;
            col <= pix.color;
            if (pix.x == px && pix.y == py) hit <= 1'h1;
            if (pix.x < xlo) xlo <= pix.x;
            if (pix.x > xhi) xhi <= pix.x;
            if (pix.y < ylo) ylo <= pix.y;
            if (pix.y > yhi) yhi <= pix.y;
        end
    end
endmodule
`default_nettype wire

//--- gse_pkg.sv
// constants, layouts and types shared by the shape drawing engine
package gse_pkg;
    // register indices; byte address on apb is four times the index
    localparam logic [7:0] IDX_LINE_CTL = 8'h67;
    localparam logic [7:0] IDX_ELL_CTL = 8'h76;
    localparam logic [7:0] IDX_PAR_LO = 8'h68;
    localparam logic [7:0] IDX_PAR_HI = 8'h73;
    localparam logic [7:0] IDX_RAD_LO = 8'h77;
    localparam logic [7:0] IDX_CTR_HI = 8'h7E;
    localparam logic [7:0] IDX_COL_LO = 8'hD2;
    localparam logic [7:0] IDX_COL_HI = 8'hD4;
    // byte slots inside the parameter store
    localparam int NBYTES = 26;
    localparam int B_SX = 0;
    localparam int B_SY = 2;
    localparam int B_EX = 4;
    localparam int B_EY = 6;
    localparam int B_TX = 8;
    localparam int B_TY = 10;
    localparam int B_R1 = 15;
    localparam int B_R2 = 17;
    localparam int B_CX = 19;
    localparam int B_CY = 21;
    localparam logic [4:0] B_COL = 5'h17;
    // control bit positions
    localparam int BIT_START = 7;
    localparam int BIT_ELL_FILL = 6;
    localparam int BIT_TRI_FILL = 5;
    localparam int BIT_TRI_SEL = 1;
    localparam int ELL_SHAPE_LSB = 4;
    localparam int QUAD_LSB = 0;
    localparam logic [1:0] SHP_ELL = 2'h0;
    localparam logic [1:0] SHP_QUAD = 2'h1;
    localparam logic [1:0] SHP_RECT = 2'h2;
    localparam logic [7:0] CTL_RST = 8'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;

    typedef enum logic [2:0] {SH_ELL, SH_QUAD, SH_RECT, SH_RRECT, SH_TRI} gse_shape_t;
    typedef enum logic [1:0] {ST_IDLE, ST_SCAN, ST_LINE, ST_DRAIN} gse_state_t;

    typedef struct packed {
        logic [15:0] sx, sy, ex, ey, tx, ty, r1, r2, cx, cy;
    } gse_geo_t;

    typedef struct packed {
        logic [15:0] x;
        logic [15:0] y;
        logic [23:0] color;
    } gse_pix_t;
endpackage

//--- gse_regfile.sv
// byte store for shape coordinates, radii and drawing colour
`timescale 1ns/10ps
`default_nettype none
module gse_regfile #(
    parameter int NBYTES = gse_pkg::NBYTES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic we,
    input wire logic [4:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [4:0] raddr,
    output logic [7:0] rdata,
    output logic [8*NBYTES-1:0] flat
);
    logic [7:0] mem [NBYTES];
    logic [7:0] next_mem [NBYTES];
    logic [7:0] next_rdata;

    // write port plus registered read port
    always_comb begin
        next_mem = mem;
        if (we && int'(waddr) < NBYTES) begin
            next_mem[waddr] = wdata;
        end
        next_rdata = (int'(raddr) < NBYTES) ? mem[raddr] : gse_pkg::BYTE_RST;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NBYTES; i++) begin
                mem[i] <= gse_pkg::BYTE_RST;
            end
            rdata <= gse_pkg::BYTE_RST;
        end else begin
            mem <= next_mem;
            rdata <= next_rdata;
        end
    end

    // whole store flattened for the engine, byte 0 lowest
    always_comb begin
        for (int i = 0; i < NBYTES; i++) begin
            flat[8*i +: 8] = mem[i];
        end
    end
endmodule
`default_nettype wire

//--- tb_gse_engine.sv
// register-level tests of the shape drawing engine
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_total++; \
    $display("wrong value t=%0t got %h exp %h", $time, a, b); end end
module tb_gse_engine;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [9:0] paddr = 10'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, pix_valid, pix_ready, hit, re, clr = 1'h1, slow = 1'h0;
    logic [15:0] px = 16'h0, py = 16'h0, cnt, xlo, xhi, ylo, yhi;
    logic [23:0] col;
    logic [7:0] rv;
    gse_pkg::gse_pix_t pix;
    int err_total = 0, samples_checked = 0;
    always #25 pclk = ~pclk;
    gse_engine #(.ADDR_W(10)) gse_engine_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pix_valid(pix_valid),
        .pix_ready(pix_ready), .pix(pix));
    gse_pixmem gse_pixmem_inst (.pclk(pclk), .presetn(presetn), .clr(clr), .slow(slow),
        .px(px), .py(py), .pix_valid(pix_valid), .pix(pix), .pix_ready(pix_ready),
        .cnt(cnt), .hit(hit), .xlo(xlo), .xhi(xhi), .ylo(ylo), .yhi(yhi), .col(col));
    // one apb transfer; held until pready is seen at an edge
    task automatic xfer(input logic w, input logic [7:0] i, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= {i, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rv = prdata[7:0];
        re = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic w16(input logic [7:0] i, input logic [15:0] v);
        xfer(1'h1, i, v[7:0]);
        xfer(1'h1, i + 8'h01, v[15:8]);
    endtask
    task automatic pts(input logic [15:0] a, b, c, d);
        w16(8'h68, a);
        w16(8'h6A, b);
        w16(8'h6C, c);
        w16(8'h6E, d);
    endtask
    // start one shape, poll until the start bit drops, judge what memory got
    task automatic run(input logic [7:0] ci, cv, input logic [15:0] qx, qy, input logic eh,
        input logic [15:0] x0, x1, y0, y1, cn);
        int n;
        clr <= 1'h1;
        px <= qx;
        py <= qy;
        @(posedge pclk);
        clr <= 1'h0;
        xfer(1'h1, ci, cv);
        n = 0;
        rv = 8'h80;
        while (rv[7] && n < 500) begin
            xfer(1'h0, ci, 8'h00);
            n++;
        end
        `CHK(rv[7], 1'h0)
        `CHK(hit, eh)
        `CHK(col, 24'h123456)
        `CHK({xlo, xhi, ylo, yhi}, {x0, x1, y0, y1})
        if (cn != 16'h0) `CHK(cnt, cn)
        $display("test ctl %h done", cv);
    endtask
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'h1;
        xfer(1'h0, 8'h67, 8'h00);
        `CHK(rv, 8'h00)
        xfer(1'h0, 8'h76, 8'h00);
        `CHK(rv, 8'h00)
        xfer(1'h0, 8'h74, 8'h00);
        `CHK({re, rv}, 9'h100)
        xfer(1'h1, 8'hD2, 8'h12);
        xfer(1'h1, 8'hD3, 8'h34);
        xfer(1'h1, 8'hD4, 8'h56);
        xfer(1'h0, 8'hD2, 8'h00);
        `CHK(rv, 8'h12)
        $display("test registers done");
        slow <= 1'h1;
        pts(16'h2, 16'h1, 16'h5, 16'h3);
        run(8'h76, 8'hA0, 16'h3, 16'h2, 1'h0, 16'h2, 16'h5, 16'h1, 16'h3, 16'hA);
        run(8'h76, 8'hE0, 16'h3, 16'h2, 1'h1, 16'h2, 16'h5, 16'h1, 16'h3, 16'hC);
        slow <= 1'h0;
        pts(16'h1, 16'h1, 16'h6, 16'h1);
        run(8'h67, 8'h80, 16'h3, 16'h1, 1'h1, 16'h1, 16'h6, 16'h1, 16'h1, 16'h6);
        w16(8'h77, 16'h2);
        w16(8'h79, 16'h2);
        w16(8'h7B, 16'h4);
        w16(8'h7D, 16'h4);
        run(8'h76, 8'h80, 16'h4, 16'h4, 1'h0, 16'h2, 16'h6, 16'h2, 16'h6, 16'h0);
        run(8'h76, 8'hC0, 16'h4, 16'h4, 1'h1, 16'h2, 16'h6, 16'h2, 16'h6, 16'h0);
        run(8'h76, 8'hD3, 16'h3, 16'h3, 1'h1, 16'h2, 16'h4, 16'h2, 16'h4, 16'h0);
        w16(8'h79, 16'h1);
        pts(16'h0, 16'h0, 16'h8, 16'h6);
        run(8'h76, 8'hF0, 16'h1, 16'h0, 1'h0, 16'h0, 16'h8, 16'h0, 16'h6, 16'h0);
        pts(16'h0, 16'h0, 16'h4, 16'h0);
        w16(8'h70, 16'h0);
        w16(8'h72, 16'h4);
        run(8'h67, 8'hA2, 16'h1, 16'h1, 1'h1, 16'h0, 16'h4, 16'h0, 16'h4, 16'h0);
        run(8'h67, 8'h82, 16'h1, 16'h1, 1'h0, 16'h0, 16'h4, 16'h0, 16'h4, 16'h0);
        give_verdict;
    end
    // watchdog for a hung handshake or poll
    initial begin
        #2000000;
        err_total++;
        give_verdict;
    end
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
endmodule
`default_nettype wire
